// [logic/slre_core.sv]
// Long-term prediction and pulse excitation encoding, one 40-sample sub-segment at a time.
// Assumes residual samples arrive as a valid/ready stream and parameter sets are taken on a pulse.
`timescale 1ns/1ps
`default_nettype none

module slre_core #(
  parameter int SMP_W = slre_pkg::SMP_W,
  parameter int DEPTH = slre_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Short-term residual stream
  input  wire logic [SMP_W-1:0] res_data,
  input  wire logic             res_valid,
  output logic                  res_ready,
  // Coded parameters per sub-segment
  output logic                  params_valid,
  output logic [1:0]            sub_index,
  output logic [6:0]            lag_code,
  output logic [1:0]            gain_code,
  output logic [1:0]            grid_code,
  output logic [5:0]            amp_code,
  output logic [38:0]           pulse_codes
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) return 16'sh7FFF;
    if (v < -48'sh8000) return -16'sh8000;
    return v[15:0];
  endfunction : sat16

  function automatic logic [5:0] amp_enc(input logic [14:0] v);
    int pos;
    pos = 9;
    if (int'(v) < slre_pkg::AMP_FINE_LIM) return 6'(v >> slre_pkg::AMP_FINE_SHIFT);
    for (int p = 9; p < 15; p++) if (v[p]) pos = p;
    return 6'(slre_pkg::AMP_FINE_CODES + slre_pkg::AMP_SEG_CODES * (pos - 9) + ((v >> (pos - 3)) & 15'h0007));
  endfunction : amp_enc

  function automatic logic [14:0] amp_dec(input logic [5:0] c);
    int seg;
    seg = (int'(c) - slre_pkg::AMP_FINE_CODES) / slre_pkg::AMP_SEG_CODES + 1;
    if (int'(c) < slre_pkg::AMP_FINE_CODES) return 15'(((int'(c) + 1) << slre_pkg::AMP_FINE_SHIFT) - 1);
    return 15'(((9 + int'(c[2:0])) << (seg + 5)) - 1);
  endfunction : amp_dec

  // ****************************************
  // State
  // ****************************************
  slre_pkg::slre_state_t st_r, st_nxt;
  logic signed [15:0] d_r [40], d_nxt [40];
  logic signed [15:0] e_r [40], e_nxt [40];
  logic signed [15:0] p_r [40], p_nxt [40];
  logic signed [15:0] h_r [120], h_nxt [120];
  logic [2:0]         pc_r [13], pc_nxt [13];
  logic [6:0]         lag_r, lag_nxt, blag_r, blag_nxt;
  logic [5:0]         i_r, i_nxt;
  logic [3:0]         tap_r, tap_nxt;
  logic [1:0]         m_r, m_nxt, bm_r, bm_nxt, sub_r, sub_nxt;
  logic signed [47:0] acc_r, acc_nxt, best_r, best_nxt, en_r, en_nxt;
  logic [1:0]         gc_r, gc_nxt;
  logic signed [15:0] bq_r, bq_nxt;
  logic [14:0]        xmax_r, xmax_nxt, xdec_r, xdec_nxt;
  logic [5:0]         ac_r, ac_nxt;
  logic               pv_r, pv_nxt;
  logic [6:0]         olag_r, olag_nxt;
  logic [1:0]         ogc_r, ogc_nxt, ogm_r, ogm_nxt, osub_r, osub_nxt;
  logic [5:0]         oac_r, oac_nxt;
  logic [38:0]        opc_r, opc_nxt;

  // ****************************************
  // Input FIFO and divider
  // ****************************************
  logic [SMP_W-1:0]   ff_data;
  logic               ff_valid, ff_ready, div_start, div_done;
  logic [31:0]        div_num, div_quot;

  slre_fifo #(.W(SMP_W), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (res_data),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .out_data  (ff_data),
    .out_valid (ff_valid),
    .out_ready (ff_ready)
  );

  slre_div #(.W(slre_pkg::DIV_W)) u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .start (div_start),
    .num   (div_num),
    .den   ({17'h00000, xdec_r}),
    .done  (div_done),
    .quot  (div_quot)
  );

  // ****************************************
  // Sequencer and datapath
  // ****************************************
  logic [7:0]         hidx;
  logic signed [6:0]  widx;
  logic [5:0]         gidx, koff;
  logic signed [15:0] hs, gs, ws, rec;
  logic signed [31:0] prod;
  logic signed [47:0] tot;
  logic signed [63:0] rlhs;
  logic [14:0]        mag;
  logic [16:0]        qa;
  logic signed [17:0] lvl;
  logic signed [33:0] rprod;

  always_comb begin
    st_nxt = st_r;  d_nxt = d_r;  e_nxt = e_r;  p_nxt = p_r;  h_nxt = h_r;  pc_nxt = pc_r;
    lag_nxt = lag_r;  blag_nxt = blag_r;  i_nxt = i_r;  tap_nxt = tap_r;  m_nxt = m_r;
    bm_nxt = bm_r;  sub_nxt = sub_r;  acc_nxt = acc_r;  best_nxt = best_r;  en_nxt = en_r;
    gc_nxt = gc_r;  bq_nxt = bq_r;  xmax_nxt = xmax_r;  xdec_nxt = xdec_r;  ac_nxt = ac_r;
    olag_nxt = olag_r;  ogc_nxt = ogc_r;  ogm_nxt = ogm_r;  oac_nxt = oac_r;
    opc_nxt = opc_r;  osub_nxt = osub_r;  pv_nxt = 1'b0;
    ff_ready = st_r == slre_pkg::S_LOAD;
    div_start = 1'b0;
    // Lag search walks lag_r; later passes use the chosen lag
    hidx = 8'(slre_pkg::HIST_LEN) + 8'(i_r) - 8'((st_r == slre_pkg::S_CORR) ? lag_r : blag_r);
    hs = h_r[hidx[6:0]];
    widx = 7'(i_r) + 7'(slre_pkg::TAP_MID) - 7'(tap_r);
    ws = (widx >= 0 && widx < 7'(slre_pkg::SUB_LEN)) ? e_r[widx[5:0]] : 16'sh0000;
    gidx = 6'(((st_r == slre_pkg::S_GRID) ? m_r : bm_r)) + 6'(slre_pkg::GRID_STEP) * i_r;
    gs = e_r[gidx];
    prod = 32'sh0;
    unique case (st_r)
      slre_pkg::S_CORR: prod = d_r[i_r] * hs;
      slre_pkg::S_ENER: prod = hs * hs;
      slre_pkg::S_LTR:  prod = bq_r * hs;
      slre_pkg::S_WGT:  prod = slre_pkg::WGT_TAP[(tap_r > 4'd5) ? 3'(tap_r - 4'd5) : 3'(4'd5 - tap_r)] * ws;
      slre_pkg::S_GRID: prod = gs * gs;
      default:          prod = 32'sh0;
    endcase
    tot = acc_r + 48'(prod);
    rlhs = 64'(best_r) <<< slre_pkg::GAIN_SHIFT;
    mag = gs[15] ? 15'(-17'(gs)) : gs[14:0];
    qa = div_quot[16:0];
    koff = 6'(i_r - 6'(bm_r));
    lvl = 18'sh0;
    rec = 16'sh0;
    // pulse only where k sits on the chosen grid
    // Grid 0 would reach k=39 as a fourteenth pulse; stop after the thirteenth
    if (i_r >= 6'(bm_r) && (koff % 6'(slre_pkg::GRID_STEP)) == 6'h00
        && koff < 6'(slre_pkg::GRID_STEP * slre_pkg::GRID_LEN)) begin
      lvl = 18'(int'(pc_r[4'(koff / 6'(slre_pkg::GRID_STEP))]) * slre_pkg::PULSE_STEP + slre_pkg::PULSE_MIN);
    end
    rprod = lvl * $signed({1'b0, xdec_r});
    rec = sat16(48'(rprod >>> slre_pkg::NORM_SHIFT));
    div_num = {2'b00, mag, 15'h0000};
    unique case (st_r)
      slre_pkg::S_LOAD: if (ff_valid) begin
        d_nxt[i_r] = ff_data;
        i_nxt = 6'(i_r + 1'b1);
        if (i_r == 6'(slre_pkg::SUB_LEN - 1)) begin
          st_nxt = slre_pkg::S_CORR;
          i_nxt = '0;
          lag_nxt = 7'(slre_pkg::LAG_MIN);
          acc_nxt = '0;
        end
      end
      slre_pkg::S_CORR: begin
        acc_nxt = tot;
        i_nxt = 6'(i_r + 1'b1);
        if (i_r == 6'(slre_pkg::SUB_LEN - 1)) begin
          i_nxt = '0;
          acc_nxt = '0;
          // Strict compare keeps the earliest lag on a tie
          if (lag_r == 7'(slre_pkg::LAG_MIN) || tot > best_r) begin
            best_nxt = tot;
            blag_nxt = lag_r;
          end
          lag_nxt = 7'(lag_r + 1'b1);
          if (lag_r == 7'(slre_pkg::LAG_MAX)) st_nxt = slre_pkg::S_ENER;
        end
      end
      slre_pkg::S_ENER: begin
        acc_nxt = tot;
        i_nxt = 6'(i_r + 1'b1);
        if (i_r == 6'(slre_pkg::SUB_LEN - 1)) begin
          en_nxt = tot;
          i_nxt = '0;
          acc_nxt = '0;
          st_nxt = slre_pkg::S_GAIN;
        end
      end
      slre_pkg::S_GAIN: begin
        // R/S > level compared as R*2^15 > S*level, no divide needed
        gc_nxt = '0;
        for (int k = 0; k < 3; k++) begin
          if (rlhs > 64'(en_r) * 64'(slre_pkg::GAIN_DEC_LVL[k])) gc_nxt = 2'(k + 1);
        end
        bq_nxt = slre_pkg::GAIN_REC_LVL[gc_nxt];
        st_nxt = slre_pkg::S_LTR;
      end
      slre_pkg::S_LTR: begin
        p_nxt[i_r] = sat16(48'(prod >>> slre_pkg::GAIN_SHIFT));
        e_nxt[i_r] = sat16(48'(d_r[i_r]) - 48'(prod >>> slre_pkg::GAIN_SHIFT));
        i_nxt = 6'(i_r + 1'b1);
        if (i_r == 6'(slre_pkg::SUB_LEN - 1)) begin
          st_nxt = slre_pkg::S_WGT;
          i_nxt = '0;
          tap_nxt = '0;
        end
      end
      slre_pkg::S_WGT: begin
        acc_nxt = tot;
        tap_nxt = 4'(tap_r + 1'b1);
        if (tap_r == 4'(slre_pkg::TAP_CNT - 1)) begin
          // Weighted samples reuse d; the residual is still needed for taps
          d_nxt[i_r] = sat16(tot >>> slre_pkg::WGT_SHIFT);
          tap_nxt = '0;
          acc_nxt = '0;
          i_nxt = 6'(i_r + 1'b1);
          if (i_r == 6'(slre_pkg::SUB_LEN - 1)) begin
            st_nxt = slre_pkg::S_GRID;
            i_nxt = '0;
            m_nxt = '0;
            e_nxt = d_nxt;
          end
        end
      end
      slre_pkg::S_GRID: begin
        acc_nxt = tot;
        i_nxt = 6'(i_r + 1'b1);
        if (i_r == 6'(slre_pkg::GRID_LEN - 1)) begin
          i_nxt = '0;
          acc_nxt = '0;
          if (m_r == 2'd0 || tot > best_r) begin
            best_nxt = tot;
            bm_nxt = m_r;
          end
          m_nxt = 2'(m_r + 1'b1);
          if (m_r == 2'(slre_pkg::GRID_CNT - 1)) begin
            st_nxt = slre_pkg::S_AMAX;
            xmax_nxt = '0;
          end
        end
      end
      slre_pkg::S_AMAX: begin
        if (mag > xmax_r) xmax_nxt = mag;
        i_nxt = 6'(i_r + 1'b1);
        if (i_r == 6'(slre_pkg::GRID_LEN - 1)) begin
          i_nxt = '0;
          st_nxt = slre_pkg::S_AMPQ;
        end
      end
      slre_pkg::S_AMPQ: begin
        ac_nxt = amp_enc(xmax_r);
        xdec_nxt = amp_dec(ac_nxt);
        st_nxt = slre_pkg::S_NORM;
      end
      slre_pkg::S_NORM: begin
        div_start = 1'b1;
        st_nxt = slre_pkg::S_NWAIT;
      end
      slre_pkg::S_NWAIT: if (div_done) begin
        // sign-magnitude quotient folded onto the eight levels
        if (!gs[15]) begin
          pc_nxt[i_r[3:0]] = 3'(slre_pkg::PULSE_ZERO + ((qa >> slre_pkg::PULSE_SHIFT) > 17'd3 ? 3 : int'(qa >> slre_pkg::PULSE_SHIFT)));
        end else if (qa == '0) begin
          pc_nxt[i_r[3:0]] = 3'(slre_pkg::PULSE_ZERO - 1);
        end else begin
          pc_nxt[i_r[3:0]] = 3'(slre_pkg::PULSE_ZERO - 1 - (((qa - 1'b1) >> slre_pkg::PULSE_SHIFT) > 17'd3 ? 3 : int'((qa - 1'b1) >> slre_pkg::PULSE_SHIFT)));
        end
        i_nxt = 6'(i_r + 1'b1);
        st_nxt = slre_pkg::S_NORM;
        if (i_r == 6'(slre_pkg::GRID_LEN - 1)) begin
          i_nxt = '0;
          st_nxt = slre_pkg::S_RECON;
        end
      end
      slre_pkg::S_RECON: begin
        d_nxt[i_r] = sat16(48'(rec) + 48'(p_r[i_r]));
        i_nxt = 6'(i_r + 1'b1);
        if (i_r == 6'(slre_pkg::SUB_LEN - 1)) begin
          i_nxt = '0;
          st_nxt = slre_pkg::S_SHIFT;
        end
      end
      slre_pkg::S_SHIFT: begin
        // Oldest 40 drop out; the next lag search sees a complete history
        for (int j = 0; j < slre_pkg::HIST_LEN; j++) begin
          h_nxt[j] = (j < slre_pkg::HIST_LEN - slre_pkg::SUB_LEN) ? h_r[j + slre_pkg::SUB_LEN]
                                                                : d_r[j + slre_pkg::SUB_LEN - slre_pkg::HIST_LEN];
        end
        st_nxt = slre_pkg::S_EMIT;
      end
      slre_pkg::S_EMIT: begin
        olag_nxt = blag_r;
        ogc_nxt = gc_r;
        ogm_nxt = bm_r;
        oac_nxt = ac_r;
        for (int k = 0; k < slre_pkg::GRID_LEN; k++) opc_nxt[3*k +: 3] = pc_r[k];
        osub_nxt = sub_r;
        sub_nxt = 2'(sub_r + 1'b1);
        pv_nxt = 1'b1;
        st_nxt = slre_pkg::S_LOAD;
      end
      default: st_nxt = slre_pkg::S_LOAD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= slre_pkg::S_LOAD;
      for (int k = 0; k < 40; k++) begin
        d_r[k] <= '0;
        e_r[k] <= '0;
        p_r[k] <= '0;
      end
      for (int k = 0; k < 120; k++) h_r[k] <= '0;
      for (int k = 0; k < 13; k++) pc_r[k] <= '0;
      lag_r <= '0;  blag_r <= '0;  i_r <= '0;  tap_r <= '0;  m_r <= '0;  bm_r <= '0;
      sub_r <= '0;  acc_r <= '0;  best_r <= '0;  en_r <= '0;  gc_r <= '0;  bq_r <= '0;
      xmax_r <= '0;  xdec_r <= '0;  ac_r <= '0;  pv_r <= 1'b0;  olag_r <= '0;
      ogc_r <= '0;  ogm_r <= '0;  oac_r <= '0;  opc_r <= '0;  osub_r <= '0;
    end else begin
      st_r <= st_nxt;  d_r <= d_nxt;  e_r <= e_nxt;  p_r <= p_nxt;  h_r <= h_nxt;
      pc_r <= pc_nxt;  lag_r <= lag_nxt;  blag_r <= blag_nxt;  i_r <= i_nxt;
      tap_r <= tap_nxt;  m_r <= m_nxt;  bm_r <= bm_nxt;  sub_r <= sub_nxt;
      acc_r <= acc_nxt;  best_r <= best_nxt;  en_r <= en_nxt;  gc_r <= gc_nxt;
      bq_r <= bq_nxt;  xmax_r <= xmax_nxt;  xdec_r <= xdec_nxt;  ac_r <= ac_nxt;
      pv_r <= pv_nxt;  olag_r <= olag_nxt;  ogc_r <= ogc_nxt;  ogm_r <= ogm_nxt;
      oac_r <= oac_nxt;  opc_r <= opc_nxt;  osub_r <= osub_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign params_valid = pv_r;
  assign sub_index    = osub_r;
  assign lag_code     = olag_r;
  assign gain_code    = ogc_r;
  assign grid_code    = ogm_r;
  assign amp_code     = oac_r;
  assign pulse_codes  = opc_r;

endmodule : slre_core

`default_nettype wire

// [logic/slre_div.sv]
// Serial restoring divider for pulse normalisation, one quotient bit per clock.
// Assumes den is nonzero; start is ignored while busy.
`timescale 1ns/1ps
`default_nettype none

module slre_div #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // Answer
  output logic              done,
  output logic [W-1:0]      quot
);
  localparam int CW = $clog2(W + 1);

  logic [W-1:0]  rem_r, rem_nxt, q_r, q_nxt, den_r, den_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          done_r, done_nxt;
  logic [W:0]    trial;

  always_comb begin
    rem_nxt  = rem_r;
    q_nxt    = q_r;
    den_nxt  = den_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    trial    = {rem_r, q_r[W-1]};
    if (cnt_r == '0) begin
      if (start) begin
        rem_nxt = '0;
        q_nxt   = num;
        den_nxt = den;
        cnt_nxt = CW'(W);
      end
    end else begin
      q_nxt = {q_r[W-2:0], 1'b0};
      if (trial >= {1'b0, den_r}) begin
        rem_nxt  = W'(trial - {1'b0, den_r});
        q_nxt[0] = 1'b1;
      end else begin
        rem_nxt = trial[W-1:0];
      end
      cnt_nxt  = CW'(cnt_r - 1'b1);
      done_nxt = cnt_r == CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rem_r  <= '0;
      q_r    <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      rem_r  <= rem_nxt;
      q_r    <= q_nxt;
      den_r  <= den_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign quot = q_r;

endmodule : slre_div

`default_nettype wire

// [logic/slre_fifo.sv]
// Sample FIFO in front of the encoder stage.
// Assumes both sides on clk; flags are registered.
`timescale 1ns/1ps
`default_nettype none

module slre_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          rdy_r, rdy_nxt, vld_r, vld_nxt, push, pop;

  always_comb begin
    push    = in_valid && rdy_r;
    pop     = out_ready && vld_r;
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    // Flags from the next count so they never lag a push or pop
    rdy_nxt = cnt_nxt != (AW+1)'(DEPTH);
    vld_nxt = cnt_nxt != '0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      vld_r <= 1'b0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      vld_r <= vld_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  assign in_ready  = rdy_r;
  assign out_valid = vld_r;
  assign out_data  = mem_r[rp_r];

endmodule : slre_fifo

`default_nettype wire

// [logic/slre_pkg.sv]
// Constants and types shared by the long-term prediction / pulse excitation encoder.
// Assumes 16-bit signed residual samples and one clock for the whole stage.
//
// How it works
// - Correlate 40 current residual samples with history at every lag 40..120.
// - Lag is the candidate with the largest cross-correlation value.
// - Gain is peak correlation over energy of 40 history samples at that lag.
// - The last 120 reconstructed residual samples persist between sub-segments.
// - Lag leaves as a 7-bit code; the local decoder uses it unchanged.
// - Gain coded to 2 bits against decision levels 0.2, 0.5, 0.8.
// - Gain codes 0..3 decode to 0.10, 0.35, 0.65, 1.00.
// - Long-term residual is short-term residual minus prediction, per sample.
// - Rebuilt short-term residual is rebuilt long-term residual plus prediction.
// - Prediction is history at the decoded lag times the decoded gain.
// - Weighting uses a symmetric 11-tap filter, taps 8192,5741,2054,0,-374,-134.
// - Filter keeps the 40 central outputs; samples outside the block are zero.
// - Four 13-sample grids take every third sample from offsets 0..3.
// - Grid with largest energy wins and leaves as a 2-bit code.
// - Largest magnitude of the 13 samples is coded log-wise into 6 bits.
// - Amplitude steps of 32 for codes 0-15, doubling every eight; decode to top.
// - Samples are normalised by the decoded amplitude, not the raw maximum.
// - Normalised samples are coded to 3 bits in steps of 8192; -28672..28672.
// - Local rebuild places dequantised pulses on the grid, zeros elsewhere.

package slre_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int SMP_W      = 16;
  localparam int SUB_LEN    = 40;
  localparam int HIST_LEN   = 120;
  localparam int LAG_MIN    = 40;
  localparam int LAG_MAX    = 120;
  localparam int GRID_LEN   = 13;
  localparam int GRID_CNT   = 4;
  localparam int GRID_STEP  = 3;
  localparam int TAP_CNT    = 11;
  localparam int TAP_MID    = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int SUBS_FRAME = 4;
  localparam int DIV_W      = 32;

  // ****************************************
  // Gain quantiser, Q15
  // ****************************************
  localparam logic signed [15:0] GAIN_DEC_LVL [0:2] = '{16'sh199A, 16'sh4000, 16'sh6666};
  localparam logic signed [15:0] GAIN_REC_LVL [0:3] = '{16'sh0CCD, 16'sh2CCD, 16'sh5333, 16'sh7FFF};
  localparam int GAIN_SHIFT = 15;

  // ****************************************
  // Weighting filter, scaled by 2^13
  // ****************************************
  localparam logic signed [15:0] WGT_TAP [0:5] =
    '{16'sh2000, 16'sh166D, 16'sh0806, 16'sh0000, -16'sh0176, -16'sh0086};
  localparam int WGT_SHIFT = 13;

  // ****************************************
  // Block amplitude and pulse quantiser
  // ****************************************
  localparam int AMP_FINE_LIM   = 512;
  localparam int AMP_FINE_SHIFT = 5;
  localparam int AMP_FINE_CODES = 16;
  localparam int AMP_SEG_CODES  = 8;
  localparam int PULSE_SHIFT    = 13;
  localparam int PULSE_ZERO     = 4;
  localparam int PULSE_STEP     = 8192;
  localparam int PULSE_MIN      = -28672;
  localparam int NORM_SHIFT     = 15;

  // ****************************************
  // Sequencer states, Gray along the usual path except EMIT back to LOAD
  // ****************************************
  typedef enum logic [3:0] {
    S_LOAD  = 4'h0, S_CORR  = 4'h1, S_ENER  = 4'h3, S_GAIN  = 4'h2,
    S_LTR   = 4'h6, S_WGT   = 4'h7, S_GRID  = 4'h5, S_AMAX  = 4'h4,
    S_AMPQ  = 4'hC, S_NORM  = 4'hD, S_NWAIT = 4'hF, S_RECON = 4'hE,
    S_SHIFT = 4'hA, S_EMIT  = 4'hB
  } slre_state_t;

endpackage : slre_pkg

// [verification/slre_core_sva.sv]
// Port checker for the encoder stage.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module slre_core_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        res_valid,
  input wire logic        res_ready,
  input wire logic        params_valid,
  input wire logic [1:0]  sub_index,
  input wire logic [6:0]  lag_code,
  input wire logic [1:0]  gain_code,
  input wire logic [1:0]  grid_code,
  input wire logic [5:0]  amp_code,
  input wire logic [38:0] pulse_codes
);
  int sets_r;
  int acc_r;
  int gap_r;
  always_ff @(posedge clk) begin
    sets_r <= !rst_n ? 0 : sets_r + int'(params_valid);
    acc_r  <= !rst_n ? 0 : acc_r + int'(res_valid && res_ready);
    gap_r  <= (!rst_n || params_valid) ? 0 : gap_r + 1;
  end
  a_reset_quiet :
    assert property (@(posedge clk) !rst_n |=> !params_valid && !res_ready && lag_code == 7'h00)
    else $error("Outputs not cleared by reset");
  a_ready_release :
    assert property (@(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> !res_ready ##1 res_ready)
    else $error("Ready late after reset");
  a_pulse_single :
    assert property (@(posedge clk) disable iff (!rst_n) params_valid |=> !params_valid)
    else $error("Parameter strobe longer than one cycle");
  a_lag_range :
    assert property (@(posedge clk) disable iff (!rst_n) params_valid |-> lag_code inside {[7'h28:7'h78]})
    else $error("Lag code out of range");
  a_codes_hold :
    assert property (@(posedge clk) disable iff (!rst_n)
      !params_valid |-> $stable({sub_index, lag_code, gain_code, grid_code, amp_code, pulse_codes}))
    else $error("Codes changed without strobe");
  a_sub_order :
    assert property (@(posedge clk) disable iff (!rst_n) params_valid |-> sub_index == sets_r[1:0])
    else $error("Sub-segment index out of order");
  a_enough_input :
    assert property (@(posedge clk) disable iff (!rst_n) params_valid |-> acc_r >= 40 * (sets_r + 1))
    else $error("Set emitted before 40 samples");
  a_set_spacing :
    assert property (@(posedge clk) disable iff (!rst_n) params_valid |-> gap_r >= 40)
    else $error("Sets closer than one load");
endmodule : slre_core_sva
bind slre_core slre_core_sva i_sva (.clk, .rst_n, .res_valid, .res_ready, .params_valid, .sub_index,
  .lag_code, .gain_code, .grid_code, .amp_code, .pulse_codes);
`default_nettype wire

// [verification/slre_src.sv]
// Residual source standing in for the short-term stage.
// Assumes the bench queues samples only after reset.
`timescale 1ns/1ps
`default_nettype none
module slre_src (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Residual stream
  output logic [15:0]      res_data,
  output logic             res_valid,
  input  wire logic        res_ready
);
  logic [15:0] q[$];
  logic        taken = 1'b0;
  initial begin
    res_data  = 16'h0000;
    res_valid = 1'b0;
  end
  always @(posedge clk) if (res_valid && res_ready) taken = 1'b1;
  // Released line shows the inverse so a stale sample cannot pass
  always @(negedge clk) begin
    if (!rst_n || taken || !res_valid) begin
      taken = 1'b0;
      res_valid = rst_n && q.size() > 0;
      if (res_valid)
        res_data = q.pop_front();
      else
        res_data = ~res_data;
    end
  end
endmodule : slre_src
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the encoder stage.
// Assumes the source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] res_data;
  logic        res_valid, res_ready, params_valid;
  logic [1:0]  sub_index, gain_code, grid_code;
  logic [6:0]  lag_code;
  logic [5:0]  amp_code;
  logic [38:0] pulse_codes;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic        refused = 1'b0;
  initial forever #25 clk = ~clk;
  slre_core i_slre_core (.clk, .rst_n, .res_data, .res_valid, .res_ready, .params_valid, .sub_index,
    .lag_code, .gain_code, .grid_code, .amp_code, .pulse_codes);
  slre_src i_slre_src (.clk, .rst_n, .res_data, .res_valid, .res_ready);
  always @(negedge clk) if (res_valid && !res_ready) refused = 1'b1;
  task automatic tally_and_finish;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic do_reset;
    @(negedge clk) rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset
  // One sub-segment: impulse at position 0, zeros after
  task automatic push_sub(input logic [15:0] a);
    i_slre_src.q.push_back(a);
    repeat (39) i_slre_src.q.push_back(16'h0000);
  endtask : push_sub
  task automatic wait_set(input logic [1:0] si, input logic [5:0] amp, input logic [38:0] pc);
    int n = 0;
    while (params_valid !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    `CHK("params_valid", 1'b1, params_valid)
    `CHK("sub_index", si, sub_index)
    `CHK("lag_code", 7'h28, lag_code)
    `CHK("gain_code", 2'h0, gain_code)
    `CHK("grid_code", 2'h0, grid_code)
    `CHK("amp_code", amp, amp_code)
    `CHK("pulse_codes", pc, pulse_codes)
    @(negedge clk);
  endtask : wait_set
  // Silent frame back to back: FIFO must refuse, then drain
  task automatic t_zero_frame;
    do_reset();
    repeat (4) push_sub(16'h0000);
    for (int j = 0; j < 4; j++) wait_set(j[1:0], 6'h00, {13{3'h4}});
    `CHK("refused", 1'b1, refused)
    `CHK("drained", 1'b0, res_valid)
  endtask : t_zero_frame
  task automatic t_impulse(input logic [15:0] a, input logic [5:0] amp, input logic [2:0] p0);
    do_reset();
    push_sub(a);
    wait_set(2'h0, amp, {{12{3'h4}}, p0});
  endtask : t_impulse
  // Echo of the first impulse fifty samples on: the kept history must yield lag 50, top gain
  task automatic t_lag_search;
    do_reset();
    push_sub(16'h01FF);
    repeat (10) i_slre_src.q.push_back(16'h0000);
    push_sub(16'h01FF);
    wait_set(2'h0, 6'h0F, {{12{3'h4}}, 3'h7});
    while (params_valid !== 1'b1) @(negedge clk);
    `CHK("sub_index", 2'h1, sub_index)
    `CHK("lag_code", 7'h32, lag_code)
    `CHK("gain_code", 2'h3, gain_code)
    @(negedge clk);
  endtask : t_lag_search
  initial begin
    t_zero_frame();
    t_impulse(16'h01FF, 6'h0F, 3'h7);
    t_impulse(16'h0200, 6'h10, 3'h7);
    t_impulse(16'hFC00, 6'h18, 3'h0);
    t_lag_search();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
